// File: src/gate_driver_params.svh
`ifndef GATE_DRIVER_PARAMS_SVH
`define GATE_DRIVER_PARAMS_SVH

// ==========================================================
// Register addresses
`define ADDR_MAIN 3'h2
`define ADDR_GATE_CFG 3'h3
`define ADDR_OC_CFG 3'h4
`define ADDR_CHOP_CFG 3'h5

// Reset values
`define RST_GATE_CFG 8'h07
`define RST_OC_CFG 8'h70
`define RST_CHOP_CFG 8'h01

// Lock field in main register
`define LOCK_LSB 3
`define LOCK_CODE 3'h6
`define UNLOCK_CODE 3'h3

// ==========================================================
// Field positions
`define DEAD_LSB 6
`define WATCHDOG_ENABLE_BIT_BIT 5
`define WD_SEL_LSB 3
`define GATE_I_LSB 0
`define LIMIT_BIT 7
`define THR_LSB 4
`define HS_DIS_BIT 1
`define LS_DIS_BIT 0
`define OC_RSVD_MASK 8'hF3
`define OFF_LSB 6
`define REG_DIS_BIT 5
`define SCALE_LSB 3
`define SH_BIT 2
`define GAIN_LSB 0

// Watchdog timeouts in ms
`define WD_MS0 10
`define WD_MS1 20
`define WD_MS2 50
`define WD_MS3 100
`define CLK_KHZ 100000

`endif

// File: src/gate_driver_pkg.sv
package gate_driver_pkg;
    typedef enum logic [1:0] {
        WD_IDLE = 2'h0,
        WD_RUN = 2'h1,
        WD_EXPIRED = 2'h3
    } wd_state_t;
endpackage

// File: src/gate_driver_config_regs.sv
`timescale 1ns/1ns
`include "gate_driver_params.svh"
module gate_driver_config_regs #(
    parameter int WD_UNIT_CYCLES = `CLK_KHZ
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic clearFault,
    input wire logic highSideTrip,
    output logic [1:0] dead_time_select,
    output logic watchdog_enable_bit,
    output logic [1:0] watchdog_timeout_select,
    output logic [2:0] gate_current_code,
    output logic shunt_output_limit,
    output logic [2:0] overcurrent_threshold_select,
    output logic high_side_monitor_disable,
    output logic low_side_monitor_disable,
    output logic [1:0] chop_off_time_select,
    output logic regulation_disable,
    output logic [1:0] refScale,
    output logic sample_hold_enable,
    output logic [1:0] ampGain,
    output logic locked,
    output logic high_side_overcurrent_flag,
    output logic watchdog_fault_flag
);

    // ==========================================================
    // Register file
    logic [7:0] gateCfg, ocCfg, chopCfg;
    logic [7:0] next_gateCfg, next_ocCfg, next_chopCfg;
    logic next_locked;
    logic [7:0] next_regRdata;

    always_comb begin
        next_gateCfg = gateCfg;
        next_ocCfg = ocCfg;
        next_chopCfg = chopCfg;
        next_locked = locked;
        if (regWrite && regAddr == `ADDR_MAIN) begin
            if (!locked && regWdata[`LOCK_LSB +: 3] == `LOCK_CODE) begin
                next_locked = 1'b1;
            end else if (locked && regWdata[`LOCK_LSB +: 3] == `UNLOCK_CODE) begin
                next_locked = 1'b0;
            end
        end
        // Lock freezes the configuration while register 2 stays writable
        if (regWrite && !locked) begin
            case (regAddr)
                `ADDR_GATE_CFG: next_gateCfg = regWdata;
                `ADDR_OC_CFG: next_ocCfg = regWdata & `OC_RSVD_MASK;
                `ADDR_CHOP_CFG: next_chopCfg = regWdata;
                default: ;
            endcase
        end
        // Unmapped addresses read zero; register 2 shows only its lock field
        case (regAddr)
            `ADDR_MAIN: next_regRdata = locked ? {2'h0, `LOCK_CODE, 3'h0}
                                               : {2'h0, `UNLOCK_CODE, 3'h0};
            `ADDR_GATE_CFG: next_regRdata = gateCfg;
            `ADDR_OC_CFG: next_regRdata = ocCfg;
            `ADDR_CHOP_CFG: next_regRdata = chopCfg;
            default: next_regRdata = 8'h00;
        endcase
        if (!regRead) begin
            next_regRdata = regRdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gateCfg <= `RST_GATE_CFG;
            ocCfg <= `RST_OC_CFG;
            chopCfg <= `RST_CHOP_CFG;
            locked <= 1'b0;
            regRdata <= 8'h00;
        end else begin
            gateCfg <= next_gateCfg;
            ocCfg <= next_ocCfg;
            chopCfg <= next_chopCfg;
            locked <= next_locked;
            regRdata <= next_regRdata;
        end
    end

    assign dead_time_select = gateCfg[`DEAD_LSB +: 2];
    assign watchdog_enable_bit = gateCfg[`WATCHDOG_ENABLE_BIT_BIT];
    assign watchdog_timeout_select = gateCfg[`WD_SEL_LSB +: 2];
    assign gate_current_code = gateCfg[`GATE_I_LSB +: 3];
    assign shunt_output_limit = ocCfg[`LIMIT_BIT];
    assign overcurrent_threshold_select = ocCfg[`THR_LSB +: 3];
    assign high_side_monitor_disable = ocCfg[`HS_DIS_BIT];
    assign low_side_monitor_disable = ocCfg[`LS_DIS_BIT];
    assign chop_off_time_select = chopCfg[`OFF_LSB +: 2];
    assign regulation_disable = chopCfg[`REG_DIS_BIT];
    assign refScale = chopCfg[`SCALE_LSB +: 2];
    assign sample_hold_enable = chopCfg[`SH_BIT];
    assign ampGain = chopCfg[`GAIN_LSB +: 2];

    // ==========================================================
    // Fault flags
    // Comparator level is asynchronous, so two flops come before any use
    logic tripMeta, tripSync, next_hsFlag;

    always_comb begin
        next_hsFlag = high_side_overcurrent_flag;
        if (clearFault) begin
            next_hsFlag = 1'b0;
        end
        // Set beats clear so a trip is never lost
        if (tripSync && !high_side_monitor_disable) begin
            next_hsFlag = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tripMeta <= 1'b0;
            tripSync <= 1'b0;
            high_side_overcurrent_flag <= 1'b0;
        end else begin
            tripMeta <= highSideTrip;
            tripSync <= tripMeta;
            high_side_overcurrent_flag <= next_hsFlag;
        end
    end

    // ==========================================================
    // Watchdog
    function automatic logic [6:0] wdMs(input logic [1:0] sel);
        case (sel)
            2'h0: wdMs = 7'(`WD_MS0);
            2'h1: wdMs = 7'(`WD_MS1);
            2'h2: wdMs = 7'(`WD_MS2);
            default: wdMs = 7'(`WD_MS3);
        endcase
    endfunction

    gate_driver_pkg::wd_state_t wdState, next_wdState;
    // Cycle prescaler then millisecond count keeps the compare narrow
    logic [16:0] unitCnt, next_unitCnt;
    logic [6:0] msCnt, next_msCnt;
    logic next_wdFault;
    logic access;

    // Reads count as host activity too, so polling alone keeps it fed
    assign access = regWrite || regRead;

    always_comb begin
        next_wdState = wdState;
        next_unitCnt = unitCnt;
        next_msCnt = msCnt;
        next_wdFault = watchdog_fault_flag;
        if (clearFault) begin
            next_wdFault = 1'b0;
        end
        case (wdState)
            gate_driver_pkg::WD_IDLE: begin
                next_unitCnt = 17'h00000;
                next_msCnt = 7'h00;
                if (watchdog_enable_bit) begin
                    next_wdState = gate_driver_pkg::WD_RUN;
                end
            end
            gate_driver_pkg::WD_RUN: begin
                if (!watchdog_enable_bit) begin
                    next_wdState = gate_driver_pkg::WD_IDLE;
                end else if (access) begin
                    next_unitCnt = 17'h00000;
                    next_msCnt = 7'h00;
                end else if (unitCnt == 17'(WD_UNIT_CYCLES - 1)) begin
                    next_unitCnt = 17'h00000;
                    next_msCnt = msCnt + 7'h01;
                    if (msCnt + 7'h01 >= wdMs(watchdog_timeout_select)) begin
                        next_wdState = gate_driver_pkg::WD_EXPIRED;
                    end
                end else begin
                    next_unitCnt = unitCnt + 17'h00001;
                end
            end
            gate_driver_pkg::WD_EXPIRED: begin
                next_wdFault = 1'b1;
                next_unitCnt = 17'h00000;
                next_msCnt = 7'h00;
                next_wdState = watchdog_enable_bit ? gate_driver_pkg::WD_RUN
                                                   : gate_driver_pkg::WD_IDLE;
            end
            default: next_wdState = gate_driver_pkg::WD_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdState <= gate_driver_pkg::WD_IDLE;
            unitCnt <= 17'h00000;
            msCnt <= 7'h00;
            watchdog_fault_flag <= 1'b0;
        end else begin
            wdState <= next_wdState;
            unitCnt <= next_unitCnt;
            msCnt <= next_msCnt;
            watchdog_fault_flag <= next_wdFault;
        end
    end

    // ==========================================================
    // Checks
    chk_lock_blocks: assert property (@(posedge core_clk) disable iff (rst)
        (locked && regWrite && regAddr != `ADDR_MAIN) |=> $stable(gateCfg)
            && $stable(ocCfg) && $stable(chopCfg))
        else $error("locked write changed config");
    chk_write_gate: assert property (@(posedge core_clk) disable iff (rst)
        (!locked && regWrite && regAddr == `ADDR_GATE_CFG) |=> gateCfg == $past(regWdata))
        else $error("gate config write lost");
    chk_write_oc: assert property (@(posedge core_clk) disable iff (rst)
        (!locked && regWrite && regAddr == `ADDR_OC_CFG)
            |=> ocCfg == ($past(regWdata) & `OC_RSVD_MASK))
        else $error("overcurrent config write lost");
    chk_write_chop: assert property (@(posedge core_clk) disable iff (rst)
        (!locked && regWrite && regAddr == `ADDR_CHOP_CFG) |=> chopCfg == $past(regWdata))
        else $error("chop config write lost");
    chk_rsvd_zero: assert property (@(posedge core_clk) disable iff (rst)
        (regRead && regAddr == `ADDR_OC_CFG) |=> regRdata[3:2] == 2'h0)
        else $error("reserved bits not zero");
    chk_hs_flag_set: assert property (@(posedge core_clk) disable iff (rst)
        (tripSync && !high_side_monitor_disable) |=> high_side_overcurrent_flag)
        else $error("high-side flag not set");
    chk_hs_flag_masked: assert property (@(posedge core_clk) disable iff (rst)
        (!high_side_overcurrent_flag && (!tripSync || high_side_monitor_disable))
            |=> !high_side_overcurrent_flag)
        else $error("high-side flag set while disabled");
    chk_wd_off: assert property (@(posedge core_clk) disable iff (rst)
        !watchdog_enable_bit |=> wdState == gate_driver_pkg::WD_IDLE)
        else $error("watchdog ran while disabled");
    chk_wd_restart: assert property (@(posedge core_clk) disable iff (rst)
        (wdState == gate_driver_pkg::WD_RUN && watchdog_enable_bit && access)
            |=> unitCnt == 17'h00000 && msCnt == 7'h00)
        else $error("access did not restart watchdog");
    chk_wd_fault: assert property (@(posedge core_clk) disable iff (rst)
        (wdState == gate_driver_pkg::WD_EXPIRED) |=> watchdog_fault_flag)
        else $error("watchdog expiry not flagged");

    // Lock, readback and clear checks
    chk_lock_set: assert property (@(posedge core_clk) disable iff (rst)
        (!locked && regWrite && regAddr == `ADDR_MAIN
            && regWdata[`LOCK_LSB +: 3] == `LOCK_CODE) |=> locked)
        else $error("lock code not taken");
    chk_unlock_taken: assert property (@(posedge core_clk) disable iff (rst)
        (locked && regWrite && regAddr == `ADDR_MAIN
            && regWdata[`LOCK_LSB +: 3] == `UNLOCK_CODE) |=> !locked)
        else $error("unlock code not taken");
    chk_lock_other: assert property (@(posedge core_clk) disable iff (rst)
        (regWrite && regAddr == `ADDR_MAIN && regWdata[`LOCK_LSB +: 3] != `LOCK_CODE
            && regWdata[`LOCK_LSB +: 3] != `UNLOCK_CODE) |=> $stable(locked))
        else $error("stray code changed lock");
    chk_read_hold: assert property (@(posedge core_clk) disable iff (rst)
        !regRead |=> $stable(regRdata))
        else $error("read data moved without a read");
    chk_read_gate: assert property (@(posedge core_clk) disable iff (rst)
        (regRead && regAddr == `ADDR_GATE_CFG) |=> regRdata == $past(gateCfg))
        else $error("gate config read wrong");
    chk_read_oc: assert property (@(posedge core_clk) disable iff (rst)
        (regRead && regAddr == `ADDR_OC_CFG) |=> regRdata == $past(ocCfg))
        else $error("overcurrent config read wrong");
    chk_read_chop: assert property (@(posedge core_clk) disable iff (rst)
        (regRead && regAddr == `ADDR_CHOP_CFG) |=> regRdata == $past(chopCfg))
        else $error("chop config read wrong");
    chk_hs_flag_clear: assert property (@(posedge core_clk) disable iff (rst)
        (clearFault && (!tripSync || high_side_monitor_disable))
            |=> !high_side_overcurrent_flag)
        else $error("high-side flag not cleared");
    chk_wd_clear: assert property (@(posedge core_clk) disable iff (rst)
        (clearFault && wdState != gate_driver_pkg::WD_EXPIRED) |=> !watchdog_fault_flag)
        else $error("watchdog fault not cleared");

endmodule

// File: bench/serial_host_model.sv
`timescale 1ns/1ns
module serial_host_model (
    input wire logic core_clk,
    output logic regWrite,
    output logic regRead,
    output logic [2:0] regAddr,
    output logic [7:0] regWdata
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 3'h0;
        regWdata = 8'h00;
    end
    // One byte per strobe; the caller sets the idle gaps, and lets some run past the timeout
    task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrite <= wr;
        regRead <= !wr;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        // Released lines show the inverse, never the stale value
        regAddr <= ~a;
        regWdata <= ~d;
    endtask
endmodule

// File: bench/gate_driver_config_regs_tb.sv
`timescale 1ns/1ns
module gate_driver_config_regs_tb;
    logic core_clk, rst, regWrite, regRead, clearFault, highSideTrip, pend;
    logic [2:0] regAddr;
    logic [7:0] regWdata, regRdata;
    logic [1:0] dead_time_select, watchdog_timeout_select, chop_off_time_select, refScale, ampGain;
    logic [2:0] gate_current_code, overcurrent_threshold_select;
    logic watchdog_enable_bit, shunt_output_limit, high_side_monitor_disable;
    logic low_side_monitor_disable, regulation_disable, sample_hold_enable, locked;
    logic high_side_overcurrent_flag, watchdog_fault_flag, lk;
    logic [7:0] shReg [3:5];
    logic [10:0] note;
    logic [7:0] exp8;
    logic [10:0] expQ [$];
    int badCount = 0, nTests = 0, seed = 32'hb9fa, ms [4] = '{10, 20, 50, 100};
    serial_host_model serial_host_model_inst (.core_clk, .regWrite, .regRead, .regAddr,
        .regWdata);
    gate_driver_config_regs #(.WD_UNIT_CYCLES(10)) gate_driver_config_regs_inst (.core_clk,
        .rst, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .clearFault, .highSideTrip,
        .dead_time_select, .watchdog_enable_bit, .watchdog_timeout_select, .gate_current_code,
        .shunt_output_limit, .overcurrent_threshold_select, .high_side_monitor_disable,
        .low_side_monitor_disable, .chop_off_time_select, .regulation_disable, .refScale,
        .sample_hold_enable, .ampGain, .locked, .high_side_overcurrent_flag,
        .watchdog_fault_flag);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp) begin
            badCount++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic testDone;
        $display("mismatches %0d of %0d compares", badCount, nTests);
        if (badCount == 0 && nTests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Shadow copy mirrors lock gating and the reserved-bit mask
    task automatic w(input logic [2:0] a, input logic [7:0] d);
        if (a == 3'h2) begin
            if (!lk && d[5:3] == 3'h6) lk = 1'b1;
            else if (lk && d[5:3] == 3'h3) lk = 1'b0;
        end else if (!lk && a >= 3'h3 && a <= 3'h5) shReg[a] = (a == 3'h4) ? d & 8'hF3 : d;
        serial_host_model_inst.xfer(1'b1, a, d);
    endtask
    task automatic r(input logic [2:0] a);
        expQ.push_back({a, a == 3'h2 ? (lk ? 8'h30 : 8'h18)
            : (a >= 3'h3 && a <= 3'h5) ? shReg[a] : 8'h00});
        serial_host_model_inst.xfer(1'b0, a, 8'h00);
    endtask
    task automatic pulse(input int n);
        @(posedge core_clk);
        clearFault <= 1'b1;
        @(posedge core_clk);
        clearFault <= 1'b0;
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    function automatic logic [7:0] fld(input logic [2:0] a);
        case (a)
            3'h3: fld = {dead_time_select, watchdog_enable_bit, watchdog_timeout_select,
                gate_current_code};
            3'h4: fld = {shunt_output_limit, overcurrent_threshold_select, 2'b00,
                high_side_monitor_disable, low_side_monitor_disable};
            3'h5: fld = {chop_off_time_select, regulation_disable, refScale,
                sample_hold_enable, ampGain};
            default: fld = 8'h00;
        endcase
    endfunction
    // ==========================================================
    // Read-back checking
    // Read data lands on the edge that takes the strobe and is checked one edge later
    always @(posedge core_clk) begin
        if (pend) begin
            note = expQ.pop_front();
            exp8 = (note[10:8] >= 3'h3 && note[10:8] <= 3'h5) ? note[7:0] : 8'h00;
            check(regRdata, note[7:0]);
            check(fld(note[10:8]), exp8);
        end
        pend <= regRead;
    end
    initial begin
        #200000;
        badCount++;
        testDone;
    end
    initial begin
        rst = 1'b1;
        clearFault = 1'b0;
        highSideTrip = 1'b0;
        lk = 1'b0;
        shReg = '{8'h07, 8'h70, 8'h01};
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (int a = 2; a < 8; a++) r(a[2:0]);
        repeat (1100) @(posedge core_clk);
        #1 check(watchdog_fault_flag, 1'b0);
        for (int k = 0; k < 12; k++) begin
            w(3'(3 + k % 3), 8'({4{k[1:0]}} ^ (k > 3 ? $random(seed) : 0)));
            r(3'(3 + k % 3));
        end
        w(3'h2, 8'h30);
        w(3'h3, 8'($random(seed)));
        w(3'h4, 8'($random(seed)));
        w(3'h2, 8'h08);
        w(3'h5, 8'hFF);
        #1 check(locked, 1'b1);
        for (int a = 2; a < 6; a++) r(a[2:0]);
        w(3'h2, 8'h18);
        w(3'h4, 8'h72);
        for (int a = 2; a < 6; a++) r(a[2:0]);
        highSideTrip <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1 check(high_side_overcurrent_flag, 1'b0);
        w(3'h4, 8'h70);
        repeat (4) @(posedge core_clk);
        #1 check(high_side_overcurrent_flag, 1'b1);
        @(posedge core_clk);
        highSideTrip <= 1'b0;
        // Let the synchroniser drain, since a live trip beats the clear
        repeat (3) @(posedge core_clk);
        pulse(2);
        check(high_side_overcurrent_flag, 1'b0);
        for (int s = 0; s < 4; s++) begin
            w(3'h3, {3'b001, s[1:0], 3'h7});
            pulse(ms[s] * 10 - 12);
            check(watchdog_fault_flag, 1'b0);
            for (int k = 0; k < 30 && watchdog_fault_flag !== 1'b1; k++) #10;
            #1 check(watchdog_fault_flag, 1'b1);
        end
        w(3'h3, 8'h27);
        pulse(1);
        repeat (5) begin
            repeat (60) @(posedge core_clk);
            r(3'h5);
        end
        #1 check(watchdog_fault_flag, 1'b0);
        w(3'h3, 8'h07);
        r(3'h3);
        repeat (4) @(posedge core_clk);
        testDone;
    end
endmodule
